//--- hdl/atu_consts.vh
`ifndef ATU_CONSTS_VH
`define ATU_CONSTS_VH

// Exception vector offsets
`define ATU_VEC_NONE        20'h00000
`define ATU_VEC_IMISS       20'h01000
`define ATU_VEC_LDMISS      20'h01100
`define ATU_VEC_STMISS      20'h01200
`define ATU_VEC_DSI         20'h00300
`define ATU_VEC_ISI         20'h00400

// Geometry
`define ATU_PAGE_BITS       12
`define ATU_SEG_BITS        28
`define ATU_VSID_W          24
`define ATU_VA_W            52
`define ATU_TLB_SETS        32
`define ATU_SET_W           5
`define ATU_BAT_N           4
`define ATU_PAGE_ENTRY_GROUP_BYTES      64
`define ATU_PTE_BYTES       8
`define ATU_PAGE_ENTRY_GROUP_SHIFT      6

// Block length mask: 11 bits, 128 Kbyte (0) up to 256 Mbyte (7ff)
`define ATU_BL_W            11
`define ATU_BLK_SHIFT       17

// Access kinds
`define ATU_KIND_FETCH      2'h0
`define ATU_KIND_LOAD       2'h1
`define ATU_KIND_STORE      2'h2

// Maintenance commands
`define ATU_CMD_NONE        3'h0
`define ATU_CMD_TLB_WR      3'h1
`define ATU_CMD_TLB_INV     3'h2
`define ATU_CMD_BAT_WR      3'h3
`define ATU_CMD_SEG_WR      3'h4

`endif

//--- hdl/atu_tlb.v
`timescale 1ns/1ps
`default_nettype none
`include "atu_consts.vh"

// Two-way, 64 entry translation buffer; lookup is combinational
module atu_tlb
(
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire [39:0] lk_vpn_i,
	output reg         lk_hit_o,
	output reg  [19:0] lk_ppn_o,
	output reg  [1:0]  lk_pp_o,
	output reg         lk_chg_o,
	input  wire        wr_en_i,
	input  wire        inv_en_i,
	input  wire [39:0] wr_vpn_i,
	input  wire [19:0] wr_ppn_i,
	input  wire [1:0]  wr_pp_i,
	input  wire        wr_chg_i,
	input  wire        wr_way_i
);

	reg  [63:0] vld_r;
	reg  [34:0] tag_r [0:63];
	reg  [19:0] ppn_r [0:63];
	reg  [1:0]  pp_r  [0:63];
	reg  [63:0] chg_r;
	wire [4:0]  lk_set;
	wire [4:0]  wr_set;
	wire [5:0]  i0;
	wire [5:0]  i1;
	wire        h0;
	wire        h1;
	integer     k;

	assign lk_set = lk_vpn_i[4:0];
	assign wr_set = wr_vpn_i[4:0];
	assign i0     = {1'b0, lk_set};
	assign i1     = {1'b1, lk_set};
	assign h0     = vld_r[i0] && (tag_r[i0] == lk_vpn_i[39:5]);
	assign h1     = vld_r[i1] && (tag_r[i1] == lk_vpn_i[39:5]);

	always @*
	begin
		lk_hit_o = h0 | h1;
		lk_ppn_o = h0 ? ppn_r[i0] : ppn_r[i1];
		lk_pp_o  = h0 ? pp_r[i0] : pp_r[i1];
		lk_chg_o = h0 ? chg_r[i0] : chg_r[i1];
	end

	always @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			vld_r <= 64'h0;
			chg_r <= 64'h0;
		end
		else if (inv_en_i)
		begin
			// Both ways of the set go: the caller may not know which way holds it
			vld_r[{1'b0, wr_set}] <= 1'b0;
			vld_r[{1'b1, wr_set}] <= 1'b0;
		end
		else if (wr_en_i)
		begin
			vld_r[{wr_way_i, wr_set}] <= 1'b1;
			chg_r[{wr_way_i, wr_set}] <= wr_chg_i;
		end
	end

	always @(posedge core_clk_i)
	begin
		if (wr_en_i && !inv_en_i)
		begin
			tag_r[{wr_way_i, wr_set}] <= wr_vpn_i[39:5];
			ppn_r[{wr_way_i, wr_set}] <= wr_ppn_i;
			pp_r[{wr_way_i, wr_set}]  <= wr_pp_i;
		end
	end

	initial
	begin
		for (k = 0; k < 64; k = k + 1)
		begin
			tag_r[k] = 35'h0;
			ppn_r[k] = 20'h0;
			pp_r[k]  = 2'h0;
		end
	end

endmodule

`default_nettype wire

//--- hdl/atu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "atu_consts.vh"

// How it works
// - Store miss or clean hit raises 01200
// - Fetch translation miss raises vector 01000
// - Load translation miss raises vector 01100
// - Translates fetch, memory data, direct-store accesses
// - Translation gated by per-side enable bits
// - 4-Gbyte space, 4-Kbyte pages, 256-Mbyte segments
// - Block sizes 128 Kbyte to 256 Mbyte
// - Effective to 52-bit virtual to physical
// - Buffer lookup same cycle, no added latency
// - Separate two-way, 64 entry buffers
// - Miss gives page group hash assistance
// - Supervisor invalidates both ways of one buffer set
// - Four-entry block arrays per side
// - Page group is 64 bytes, eight entries
// - Protection checked on block and page
module atu_top
(
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire        instr_translate_enable_i,
	input  wire        data_translate_enable_i,
	input  wire        supervisor_i,
	input  wire        req_valid_i,
	input  wire [1:0]  req_kind_i,
	input  wire        req_direct_store_i,
	input  wire [31:0] req_ea_i,
	input  wire [2:0]  cmd_i,
	input  wire        cmd_data_side_i,
	input  wire [3:0]  cmd_index_i,
	input  wire [39:0] cmd_vpn_i,
	input  wire [19:0] cmd_ppn_i,
	input  wire [1:0]  cmd_pp_i,
	input  wire        cmd_chg_i,
	input  wire        cmd_way_i,
	input  wire [14:0] cmd_blk_epi_i,
	input  wire [10:0] cmd_blk_len_i,
	input  wire [1:0]  cmd_blk_vld_i,
	input  wire [23:0] cmd_vsid_i,
	input  wire [15:0] table_base_i,
	input  wire [8:0]  table_mask_i,
	output wire        rsp_valid_o,
	output reg  [31:0] rsp_pa_o,
	output reg  [51:0] rsp_va_o,
	output reg         rsp_block_o,
	output reg         rsp_fault_o,
	output reg  [19:0] rsp_vector_o,
	output reg  [31:0] rsp_page_entry_group_addr_o
);

	// ****************************************
	// Segment registers and lookups
	// ****************************************
	reg  [23:0] seg_vsid_r [0:15];
	reg  [14:0] bat_epi_r  [0:7];
	reg  [14:0] bat_rpn_r  [0:7];
	reg  [10:0] bat_len_r  [0:7];
	reg  [1:0]  bat_vld_r  [0:7];
	reg  [1:0]  bat_pp_r   [0:7];
	reg         rsp_valid_r;
	integer     k;

	wire        is_fetch = (req_kind_i == `ATU_KIND_FETCH);
	wire        is_store = (req_kind_i == `ATU_KIND_STORE);
	wire        xlate_on = is_fetch ? instr_translate_enable_i : data_translate_enable_i;
	// 52-bit virtual address: VSID, page index, byte offset
	wire [23:0] vsid     = seg_vsid_r[req_ea_i[31:28]];
	wire [51:0] va       = {vsid, req_ea_i[27:0]};
	wire [39:0] vpn      = va[51:12];

	wire        instr_xlate_buffer_hit;
	wire        data_xlate_buffer_hit;
	wire [19:0] instr_xlate_buffer_ppn;
	wire [19:0] data_xlate_buffer_ppn;
	wire [1:0]  instr_xlate_buffer_pp;
	wire [1:0]  data_xlate_buffer_pp;
	wire        instr_xlate_buffer_chg;
	wire        data_xlate_buffer_chg;
	wire        tlb_wr  = (cmd_i == `ATU_CMD_TLB_WR);
	wire        tlb_inv = (cmd_i == `ATU_CMD_TLB_INV) && supervisor_i;

	// Separate buffers per side
	atu_tlb u_instr_xlate_buffer
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.lk_vpn_i   (vpn),
		.lk_hit_o   (instr_xlate_buffer_hit),
		.lk_ppn_o   (instr_xlate_buffer_ppn),
		.lk_pp_o    (instr_xlate_buffer_pp),
		.lk_chg_o   (instr_xlate_buffer_chg),
		.wr_en_i    (tlb_wr && !cmd_data_side_i),
		.inv_en_i   (tlb_inv && !cmd_data_side_i),
		.wr_vpn_i   (cmd_vpn_i),
		.wr_ppn_i   (cmd_ppn_i),
		.wr_pp_i    (cmd_pp_i),
		.wr_chg_i   (cmd_chg_i),
		.wr_way_i   (cmd_way_i)
	);

	atu_tlb u_data_xlate_buffer
	(
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.lk_vpn_i   (vpn),
		.lk_hit_o   (data_xlate_buffer_hit),
		.lk_ppn_o   (data_xlate_buffer_ppn),
		.lk_pp_o    (data_xlate_buffer_pp),
		.lk_chg_o   (data_xlate_buffer_chg),
		.wr_en_i    (tlb_wr && cmd_data_side_i),
		.inv_en_i   (tlb_inv && cmd_data_side_i),
		.wr_vpn_i   (cmd_vpn_i),
		.wr_ppn_i   (cmd_ppn_i),
		.wr_pp_i    (cmd_pp_i),
		.wr_chg_i   (cmd_chg_i),
		.wr_way_i   (cmd_way_i)
	);

	// ****************************************
	// Helper functions
	// ****************************************
	// Protection check: pp 0 none(user), 1 read only(user), 2 rw, 3 read only
	function prot_ok;
		input [1:0] pp;
		input       sup;
		input       wr;
		begin
			case (pp)
				2'h0:    prot_ok = sup;
				2'h1:    prot_ok = sup | !wr;
				2'h2:    prot_ok = 1'b1;
				default: prot_ok = !wr;
			endcase
		end
	endfunction

	// Primary hash: low VSID bits xor va[30:12], page index plus three VSID bits
	function [31:0] page_entry_group_addr;
		input [51:0] v;
		input [15:0] base;
		input [8:0]  mask;
		reg   [18:0] h;
		begin
			h = v[30:12] ^ v[46:28];
			page_entry_group_addr = {base[15:9], (base[8:0] | (h[18:10] & mask)), h[9:0], 6'h00};
		end
	endfunction

	// ****************************************
	// Block array match, lowest index first
	// ****************************************
	reg         bat_hit;
	reg  [31:0] bat_pa;
	reg  [1:0]  bat_pp;
	reg  [2:0]  bi;
	integer     j;

	always @*
	begin
		bat_hit = 1'b0;
		bat_pa  = 32'h0;
		bat_pp  = 2'h0;
		bi      = 3'h0;
		for (j = 3; j >= 0; j = j - 1)
		begin
			bi = {!is_fetch, j[1:0]};
			// Length mask widens the block from 128 Kbyte up to 256 Mbyte
			if ((bat_vld_r[bi][supervisor_i ? 1 : 0]) &&
			    ((req_ea_i[31:17] & ~{4'h0, bat_len_r[bi]}) == bat_epi_r[bi]))
			begin
				bat_hit = 1'b1;
				bat_pp  = bat_pp_r[bi];
				bat_pa  = {(bat_rpn_r[bi] | (req_ea_i[31:17] & {4'h0, bat_len_r[bi]})), req_ea_i[16:0]};
			end
		end
	end

	// ****************************************
	// Result selection
	// ****************************************
	wire        tlb_hit = is_fetch ? instr_xlate_buffer_hit : data_xlate_buffer_hit;
	wire [19:0] tlb_ppn = is_fetch ? instr_xlate_buffer_ppn : data_xlate_buffer_ppn;
	wire [1:0]  tlb_pp  = is_fetch ? instr_xlate_buffer_pp : data_xlate_buffer_pp;
	// Direct-store accesses carry no page mapping; block hit, else a miss fault while translating
	wire        use_tlb = !req_direct_store_i && tlb_hit;

	reg  [31:0] pa_nxt;
	reg  [19:0] vec_nxt;
	reg         fault_nxt;

	always @*
	begin
		pa_nxt    = req_ea_i;
		vec_nxt   = `ATU_VEC_NONE;
		fault_nxt = 1'b0;
		if (xlate_on)
		begin
			if (bat_hit)
			begin
				pa_nxt = bat_pa;
				if (!prot_ok(bat_pp, supervisor_i, is_store))
				begin
					fault_nxt = 1'b1;
					vec_nxt   = is_fetch ? `ATU_VEC_ISI : `ATU_VEC_DSI;
				end
			end
			else if (use_tlb)
			begin
				pa_nxt = {tlb_ppn, req_ea_i[11:0]};
				if (!prot_ok(tlb_pp, supervisor_i, is_store))
				begin
					fault_nxt = 1'b1;
					vec_nxt   = is_fetch ? `ATU_VEC_ISI : `ATU_VEC_DSI;
				end
				else if (is_store && !data_xlate_buffer_chg)
				begin
					fault_nxt = 1'b1;
					vec_nxt   = `ATU_VEC_STMISS;
				end
			end
			else
			begin
				fault_nxt = 1'b1;
				case (req_kind_i)
					`ATU_KIND_FETCH: vec_nxt = `ATU_VEC_IMISS;
					`ATU_KIND_LOAD:  vec_nxt = `ATU_VEC_LDMISS;
					default:         vec_nxt = `ATU_VEC_STMISS;
				endcase
			end
		end
	end

	// ****************************************
	// Registered answer, one cycle after request
	// ****************************************
	// The one cycle is the cache access stage; the lookup rides alongside it
	assign rsp_valid_o = rsp_valid_r;

	always @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rsp_valid_r     <= 1'b0;
			rsp_pa_o        <= 32'h0;
			rsp_va_o        <= 52'h0;
			rsp_block_o     <= 1'b0;
			rsp_fault_o     <= 1'b0;
			rsp_vector_o    <= `ATU_VEC_NONE;
			rsp_page_entry_group_addr_o <= 32'h0;
		end
		else
		begin
			rsp_valid_r <= req_valid_i;
			if (req_valid_i)
			begin
				rsp_pa_o        <= pa_nxt;
				rsp_va_o        <= va;
				rsp_block_o     <= xlate_on && bat_hit;
				rsp_fault_o     <= fault_nxt;
				rsp_vector_o    <= vec_nxt;
				rsp_page_entry_group_addr_o <= page_entry_group_addr(va, table_base_i, table_mask_i);
			end
		end
	end

	// ****************************************
	// Segment and block array maintenance
	// ****************************************
	always @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (k = 0; k < 8; k = k + 1)
				bat_vld_r[k] <= 2'h0;
		end
		else if (cmd_i == `ATU_CMD_BAT_WR && supervisor_i)
			bat_vld_r[{cmd_data_side_i, cmd_index_i[1:0]}] <= cmd_blk_vld_i;
	end

	always @(posedge core_clk_i)
	begin
		if (cmd_i == `ATU_CMD_BAT_WR && supervisor_i)
		begin
			bat_epi_r[{cmd_data_side_i, cmd_index_i[1:0]}] <= cmd_blk_epi_i;
			bat_rpn_r[{cmd_data_side_i, cmd_index_i[1:0]}] <= cmd_ppn_i[19:5];
			bat_len_r[{cmd_data_side_i, cmd_index_i[1:0]}] <= cmd_blk_len_i;
			bat_pp_r[{cmd_data_side_i, cmd_index_i[1:0]}]  <= cmd_pp_i;
		end
		if (cmd_i == `ATU_CMD_SEG_WR && supervisor_i)
			seg_vsid_r[cmd_index_i] <= cmd_vsid_i;
	end

	initial
	begin
		for (k = 0; k < 16; k = k + 1)
			seg_vsid_r[k] = 24'h0;
		for (k = 0; k < 8; k = k + 1)
		begin
			bat_epi_r[k] = 15'h0;
			bat_rpn_r[k] = 15'h0;
			bat_len_r[k] = 11'h0;
			bat_pp_r[k]  = 2'h0;
		end
	end

endmodule

`default_nettype wire

//--- verif/atu_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "atu_consts.vh"
module atu_checker
(
	input wire logic        core_clk_i,
	input wire logic        rstn_i,
	input wire logic        instr_translate_enable_i,
	input wire logic        data_translate_enable_i,
	input wire logic        req_valid_i,
	input wire logic [1:0]  req_kind_i,
	input wire logic [31:0] req_ea_i,
	input wire logic        rsp_valid_o,
	input wire logic [31:0] rsp_pa_o,
	input wire logic        rsp_fault_o,
	input wire logic [19:0] rsp_vector_o,
	input wire logic [31:0] rsp_page_entry_group_addr_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_fetch_off;
		req_valid_i && req_kind_i == `ATU_KIND_FETCH && !instr_translate_enable_i;
	endsequence
	sequence s_data_off;
		req_valid_i && req_kind_i != `ATU_KIND_FETCH && !data_translate_enable_i;
	endsequence

	rsp_latency_a: assert property (req_valid_i |=> rsp_valid_o)
		else $error("answer missing one cycle after request");
	rsp_spurious_a: assert property (!req_valid_i |=> !rsp_valid_o)
		else $error("answer without request");
	ioff_pass_a: assert property (s_fetch_off |=> rsp_pa_o == $past(req_ea_i) && !rsp_fault_o)
		else $error("fetch not passed through while untranslated");
	doff_pass_a: assert property (s_data_off |=> rsp_pa_o == $past(req_ea_i) && !rsp_fault_o)
		else $error("data not passed through while untranslated");
	page_offset_a: assert property (req_valid_i |=> rsp_fault_o || rsp_pa_o[11:0] == $past(req_ea_i[11:0]))
		else $error("page offset altered");
	fetch_vec_a: assert property (req_valid_i && req_kind_i == `ATU_KIND_FETCH |=>
		!rsp_fault_o || rsp_vector_o inside {`ATU_VEC_IMISS, `ATU_VEC_ISI})
		else $error("fetch fault with wrong vector");
	store_vec_a: assert property (req_valid_i && req_kind_i == `ATU_KIND_STORE |=>
		!rsp_fault_o || rsp_vector_o inside {`ATU_VEC_STMISS, `ATU_VEC_DSI})
		else $error("store fault with wrong vector");
	group_align_a: assert property (rsp_valid_o |-> rsp_page_entry_group_addr_o[5:0] == 6'h00)
		else $error("group address not 64 byte aligned");
endmodule
`default_nettype wire

//--- verif/atu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module atu_core_model
(
	input  wire logic        clk_i,
	input  wire logic        rsp_valid_i,
	output var  logic        req_valid_o,
	output var  logic [1:0]  req_kind_o,
	output var  logic [31:0] req_ea_o,
	output var  logic        req_ds_o,
	output var  logic        got_o
);
	initial
	begin
		req_valid_o = 1'b0;
		req_kind_o = 2'h0;
		req_ea_o = 32'h0;
		req_ds_o = 1'b0;
		got_o = 1'b0;
	end

	// One-cycle request pulse, answer sampled where it stands
	task automatic issue(input logic [1:0] k, input logic [31:0] a, input logic d);
		@(posedge clk_i);
		req_valid_o <= 1'b1;
		req_kind_o <= k;
		req_ea_o <= a;
		req_ds_o <= d;
		@(posedge clk_i);
		req_valid_o <= 1'b0;
		// Released address shows no stale value
		req_ea_o <= ~a;
		#1 got_o = rsp_valid_i;
	endtask
endmodule
`default_nettype wire

//--- verif/tb_atu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "atu_consts.vh"
module tb_atu_top;
	logic        core_clk_i = 0, rstn_i = 0, supervisor_i = 0, cmd_data_side_i = 0, cmd_chg_i = 0, cmd_way_i = 0;
	logic        instr_translate_enable_i = 0, data_translate_enable_i = 0;
	logic        req_valid_i, req_direct_store_i, rsp_valid_o, rsp_block_o, rsp_fault_o, got;
	logic [1:0]  req_kind_i, cmd_pp_i = 0, cmd_blk_vld_i = 0;
	logic [2:0]  cmd_i = 0;
	logic [3:0]  cmd_index_i = 0;
	logic [39:0] cmd_vpn_i = 0;
	logic [19:0] cmd_ppn_i = 0, rsp_vector_o;
	logic [14:0] cmd_blk_epi_i = 0;
	logic [10:0] cmd_blk_len_i = 0;
	logic [23:0] cmd_vsid_i = 0;
	logic [15:0] table_base_i = 16'h1200;
	logic [8:0]  table_mask_i = 9'h003;
	logic [31:0] req_ea_i, rsp_pa_o, rsp_page_entry_group_addr_o;
	logic [51:0] rsp_va_o;
	int          n_mismatch = 0, compares = 0;
	localparam logic [31:0] EA = 32'h4000_3abc;
	localparam logic [31:0] EB = 32'h4002_3abc;
	localparam logic [23:0] VSID = 24'habcde1;

	always #5 core_clk_i = ~core_clk_i;

	atu_top dut (.core_clk_i, .rstn_i, .instr_translate_enable_i, .data_translate_enable_i, .supervisor_i,
		.req_valid_i, .req_kind_i, .req_direct_store_i, .req_ea_i, .cmd_i, .cmd_data_side_i, .cmd_index_i,
		.cmd_vpn_i, .cmd_ppn_i, .cmd_pp_i, .cmd_chg_i, .cmd_way_i, .cmd_blk_epi_i, .cmd_blk_len_i,
		.cmd_blk_vld_i, .cmd_vsid_i, .table_base_i, .table_mask_i, .rsp_valid_o, .rsp_pa_o, .rsp_va_o,
		.rsp_block_o, .rsp_fault_o, .rsp_vector_o, .rsp_page_entry_group_addr_o);
	atu_core_model pm (.clk_i(core_clk_i), .rsp_valid_i(rsp_valid_o), .req_valid_o(req_valid_i),
		.req_kind_o(req_kind_i), .req_ea_o(req_ea_i), .req_ds_o(req_direct_store_i), .got_o(got));

	// ****************
	// Helpers
	// ****************
	task chk(input logic [51:0] g, input logic [51:0] e);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task req(input logic [1:0] k, input logic [31:0] a);
		pm.issue(k, a, 1'b0);
		chk(got, 1'b1);
	endtask

	task cmd(input logic [2:0] c, input logic s, input logic [39:0] v, input logic [19:0] p,
		input logic [1:0] pp, input logic w);
		@(posedge core_clk_i);
		cmd_i <= c;
		cmd_data_side_i <= s;
		cmd_vpn_i <= v;
		cmd_ppn_i <= p;
		cmd_pp_i <= pp;
		cmd_way_i <= w;
		cmd_chg_i <= w;
		@(posedge core_clk_i);
		cmd_i <= `ATU_CMD_NONE;
	endtask

	task final_report;
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task t_off;
		for (int k = 0; k < 3; k++)
		begin
			req(k[1:0], EA);
			chk(rsp_pa_o, EA);
			chk(rsp_fault_o, 1'b0);
		end
	endtask

	task t_miss;
		logic [18:0] h;
		logic [19:0] vec [3];
		// Hash input is va[30:12], whose top three bits are low segment id bits
		h = {VSID[2:0], EA[27:12]} ^ VSID[18:0];
		vec = '{`ATU_VEC_IMISS, `ATU_VEC_LDMISS, `ATU_VEC_STMISS};
		@(posedge core_clk_i);
		instr_translate_enable_i <= 1'b1;
		data_translate_enable_i <= 1'b1;
		supervisor_i <= 1'b1;
		cmd_index_i <= 4'h4;
		cmd_vsid_i <= VSID;
		cmd(`ATU_CMD_SEG_WR, 1'b0, 40'h0, 20'h0, 2'h0, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			req(k[1:0], EA);
			chk(rsp_vector_o, vec[k]);
			chk(rsp_va_o, {VSID, EA[27:0]});
			chk(rsp_page_entry_group_addr_o, {table_base_i[15:9], table_base_i[8:0] | (h[18:10] & table_mask_i),
				h[9:0], 6'h00});
		end
	endtask

	task t_page;
		cmd(`ATU_CMD_TLB_WR, 1'b1, {VSID, EA[27:12]}, 20'h00abc, 2'h2, 1'b0);
		cmd(`ATU_CMD_TLB_WR, 1'b1, {VSID, EB[27:12]}, 20'h00def, 2'h3, 1'b1);
		cmd(`ATU_CMD_TLB_WR, 1'b0, {VSID, EA[27:12]}, 20'h00abc, 2'h2, 1'b0);
		req(`ATU_KIND_FETCH, EA);
		chk(rsp_pa_o, {20'h00abc, EA[11:0]});
		req(`ATU_KIND_LOAD, EB);
		chk(rsp_pa_o, {20'h00def, EB[11:0]});
		req(`ATU_KIND_STORE, EA);
		chk(rsp_vector_o, `ATU_VEC_STMISS);
		req(`ATU_KIND_STORE, EB);
		chk(rsp_vector_o, `ATU_VEC_DSI);
		// Direct-store access must not use the page entry that a plain load hits
		pm.issue(`ATU_KIND_LOAD, EA, 1'b1);
		chk(got, 1'b1);
		chk(rsp_vector_o, `ATU_VEC_LDMISS);
	endtask

	task t_inv;
		@(posedge core_clk_i);
		supervisor_i <= 1'b0;
		cmd(`ATU_CMD_TLB_INV, 1'b1, {VSID, EA[27:12]}, 20'h0, 2'h0, 1'b0);
		req(`ATU_KIND_LOAD, EA);
		chk(rsp_fault_o, 1'b0);
		@(posedge core_clk_i);
		supervisor_i <= 1'b1;
		cmd(`ATU_CMD_TLB_INV, 1'b1, {VSID, EA[27:12]}, 20'h0, 2'h0, 1'b0);
		req(`ATU_KIND_LOAD, EA);
		chk(rsp_vector_o, `ATU_VEC_LDMISS);
	endtask

	task t_block;
		cmd(`ATU_CMD_TLB_WR, 1'b1, {VSID, EA[27:12]}, 20'h00abc, 2'h2, 1'b1);
		@(posedge core_clk_i);
		cmd_index_i <= 4'h1;
		cmd_blk_epi_i <= EA[31:17];
		cmd_blk_vld_i <= 2'h3;
		cmd(`ATU_CMD_BAT_WR, 1'b1, 40'h0, {15'h1555, 5'h00}, 2'h2, 1'b0);
		req(`ATU_KIND_LOAD, EA);
		chk(rsp_block_o, 1'b1);
		chk(rsp_pa_o, {15'h1555, EA[16:0]});
		// EB lies in the next 128 Kbyte block, outside the smallest size
		req(`ATU_KIND_LOAD, EB);
		chk(rsp_block_o, 1'b0);
		@(posedge core_clk_i);
		cmd_blk_len_i <= 11'h7ff;
		// A 256 Mbyte block needs a base aligned to its size
		cmd(`ATU_CMD_BAT_WR, 1'b1, 40'h0, {15'h1000, 5'h00}, 2'h2, 1'b0);
		req(`ATU_KIND_LOAD, EB);
		chk(rsp_block_o, 1'b1);
		chk(rsp_pa_o, {4'h2, EB[27:0]});
	endtask

	initial
	begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_off;
		t_miss;
		t_page;
		t_inv;
		t_block;
		final_report;
	end

	initial
	begin
		#100us;
		n_mismatch++;
		final_report;
	end
endmodule

bind atu_top atu_checker chk_u (.core_clk_i, .rstn_i, .instr_translate_enable_i, .data_translate_enable_i,
	.req_valid_i, .req_kind_i, .req_ea_i, .rsp_valid_o, .rsp_pa_o, .rsp_fault_o, .rsp_vector_o, .rsp_page_entry_group_addr_o);
`default_nettype wire
